// [logic/prh_pkg.sv]
// Constants and types for the position report handshake controller
package prh_pkg;
    localparam int unsigned CLK_KHZ = 200_000;
    localparam int unsigned SAMPLE_DELAY_MS = 10;
    localparam int unsigned SAMPLE_DELAY_CYC = SAMPLE_DELAY_MS * CLK_KHZ;
    localparam int unsigned MODE_TIMEOUT_MS = 5000;
    localparam int unsigned MODE_TIMEOUT_CYC = MODE_TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned REQ_TIMEOUT_MS = 1000;
    localparam int unsigned REQ_TIMEOUT_CYC = REQ_TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned RTS_TIMEOUT_MS = 1000;
    localparam int unsigned RTS_TIMEOUT_CYC = RTS_TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned RETRY_WAIT_MS = 100;
    localparam int unsigned RETRY_WAIT_CYC = RETRY_WAIT_MS * CLK_KHZ;
    localparam int TMR_W = 32;
    localparam int POS_W = 32;
    localparam int HALF_W = 16;
    localparam int SUM_W = 6;
    localparam int ACC_W = 8;
    localparam int STEP_W = 5;
    localparam int RETRY_W = 2;
    localparam int PIN_W = 4;
    localparam logic [STEP_W-1:0] POS_STEPS = 5'h10;
    localparam logic [STEP_W-1:0] ALL_STEPS = 5'h13;
    localparam logic [RETRY_W-1:0] MAX_RETRIES = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_RDY, ST_DWELL, ST_WAIT_REL, ST_CHECK, ST_RETRY_WAIT
    } prh_state_e;
endpackage : prh_pkg

// [logic/prh_position_report_host.sv]
// Controller end of the multi-turn position report handshake
`timescale 1ns/100ps
module prh_position_report_host #(
    parameter int unsigned SAMPLE_CYC = prh_pkg::SAMPLE_DELAY_CYC,
    parameter int unsigned MODE_TO_CYC = prh_pkg::MODE_TIMEOUT_CYC,
    parameter int unsigned REQ_TO_CYC = prh_pkg::REQ_TIMEOUT_CYC,
    parameter int unsigned RTS_TO_CYC = prh_pkg::RTS_TIMEOUT_CYC,
    parameter int unsigned RETRY_CYC = prh_pkg::RETRY_WAIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // User commands
    input wire logic servo_on_req_i,
    input wire logic xfer_start_i,
    input wire logic torque_limit_req_i,
    input wire logic home_mode_i,
    input wire logic home_set_start_i,
    input wire logic rev_done_i,
    input wire logic clear_req_i,
    // User status
    output logic [prh_pkg::HALF_W-1:0] pos_lo_o,
    output logic [prh_pkg::HALF_W-1:0] pos_hi_o,
    output logic pos_valid_o,
    output logic busy_o,
    output logic csum_err_o,
    output logic comm_err_o,
    output logic hold_motion_o,
    output logic home_fix_o,
    output logic brake_relay_o,
    // Amplifier pins
    input wire logic [1:0] amp_data_i,
    input wire logic amp_rts_i,
    input wire logic amp_brake_i,
    output logic servo_on_input_o,
    output logic abs_mode_o,
    output logic abs_req_o,
    output logic torque_limit_o,
    output logic position_clear_input_o
);
    import prh_pkg::*;

    // Pin synchronisers: a change counts once stages two and three agree
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_r, s2_r, s3_r, pin_r;
    assign pin_raw = {amp_brake_i, amp_rts_i, amp_data_i};
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    pin_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pin_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        pin_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate
    logic [1:0] data_f;
    logic rts_f;
    assign data_f = pin_r[1:0];
    assign rts_f = pin_r[2];

    prh_state_e state_r, state_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt, mode_tmr_r, mode_tmr_nxt, req_tmr_r, req_tmr_nxt;
    logic [STEP_W-1:0] step_r, step_nxt;
    logic [RETRY_W-1:0] retry_r, retry_nxt;
    logic [POS_W-1:0] shift_r, shift_nxt;
    logic [SUM_W-1:0] csum_r, csum_nxt;
    logic [ACC_W-1:0] sum_r, sum_nxt;
    logic mode_r, mode_nxt, req_r, req_nxt, valid_r, valid_nxt;
    logic cserr_r, cserr_nxt, cmerr_r, cmerr_nxt;
    logic start_d_r, servo_d_r, home_d_r, trig;
    logic [POS_W-1:0] pos_r, pos_nxt;

    // Resends follow servo-on, controller run and alarm or stop recovery; user flags them
    assign trig = servo_on_req_i && ((xfer_start_i && !start_d_r) || !servo_d_r);

    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_r + TMR_W'(1);
        mode_tmr_nxt = mode_r ? mode_tmr_r + TMR_W'(1) : '0;
        req_tmr_nxt = req_r ? req_tmr_r + TMR_W'(1) : '0;
        step_nxt = step_r;
        retry_nxt = retry_r;
        shift_nxt = shift_r;
        csum_nxt = csum_r;
        sum_nxt = sum_r;
        mode_nxt = mode_r;
        req_nxt = req_r;
        valid_nxt = valid_r;
        cserr_nxt = cserr_r;
        cmerr_nxt = cmerr_r;
        pos_nxt = pos_r;
        unique case (state_r)
            ST_IDLE: begin
                if (trig) begin
                    // Pin still shows torque limit; request once the strobe is seen low
                    mode_nxt = 1'b1;
                    retry_nxt = '0;
                    valid_nxt = 1'b0;
                    cserr_nxt = 1'b0;
                    cmerr_nxt = 1'b0;
                    step_nxt = '0;
                    sum_nxt = '0;
                    tmr_nxt = '0;
                    state_nxt = ST_WAIT_REL;
                end
            end
            ST_WAIT_RDY: begin
                if (rts_f) begin
                    tmr_nxt = '0;
                    state_nxt = ST_DWELL;
                end else if (tmr_r >= TMR_W'(RTS_TO_CYC)) begin
                    cmerr_nxt = 1'b1;
                end
            end
            ST_DWELL: begin
                if (tmr_r == TMR_W'(SAMPLE_CYC - 1)) begin
                    req_nxt = 1'b0;
                    tmr_nxt = '0;
                    step_nxt = step_r + STEP_W'(1);
                    if (step_r < POS_STEPS) begin
                        shift_nxt = {data_f, shift_r[POS_W-1:2]};
                        sum_nxt = sum_r + ACC_W'(data_f);
                    end else begin
                        csum_nxt = {data_f, csum_r[SUM_W-1:2]};
                    end
                    state_nxt = ST_WAIT_REL;
                end
            end
            ST_WAIT_REL: begin
                if (!rts_f) begin
                    tmr_nxt = '0;
                    if (step_r == ALL_STEPS) begin
                        state_nxt = ST_CHECK;
                    end else begin
                        req_nxt = 1'b1;
                        state_nxt = ST_WAIT_RDY;
                    end
                end else if (tmr_r >= TMR_W'(RTS_TO_CYC)) begin
                    cmerr_nxt = 1'b1;
                end
            end
            ST_CHECK: begin
                mode_nxt = 1'b0;
                tmr_nxt = '0;
                if (sum_r[SUM_W-1:0] == csum_r) begin
                    pos_nxt = shift_r;
                    valid_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else if (retry_r != MAX_RETRIES) begin
                    retry_nxt = retry_r + RETRY_W'(1);
                    state_nxt = ST_RETRY_WAIT;
                end else begin
                    cserr_nxt = 1'b1;
                    valid_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_RETRY_WAIT: begin
                if (tmr_r >= TMR_W'(RETRY_CYC)) begin
                    mode_nxt = 1'b1;
                    step_nxt = '0;
                    sum_nxt = '0;
                    tmr_nxt = '0;
                    state_nxt = ST_WAIT_REL;
                end
            end
        endcase
        if (mode_tmr_r >= TMR_W'(MODE_TO_CYC) || req_tmr_r >= TMR_W'(REQ_TO_CYC)) begin
            cmerr_nxt = 1'b1;
        end
        // Any timeout abandons the transfer so the amplifier sees mode and request drop
        if (cmerr_nxt && !cmerr_r) begin
            mode_nxt = 1'b0;
            req_nxt = 1'b0;
            valid_nxt = 1'b0;
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            tmr_r <= '0;
            mode_tmr_r <= '0;
            req_tmr_r <= '0;
            step_r <= '0;
            retry_r <= '0;
            shift_r <= '0;
            csum_r <= '0;
            sum_r <= '0;
            mode_r <= 1'b0;
            req_r <= 1'b0;
            valid_r <= 1'b0;
            cserr_r <= 1'b0;
            cmerr_r <= 1'b0;
            pos_r <= '0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            mode_tmr_r <= mode_tmr_nxt;
            req_tmr_r <= req_tmr_nxt;
            step_r <= step_nxt;
            retry_r <= retry_nxt;
            shift_r <= shift_nxt;
            csum_r <= csum_nxt;
            sum_r <= sum_nxt;
            mode_r <= mode_nxt;
            req_r <= req_nxt;
            valid_r <= valid_nxt;
            cserr_r <= cserr_nxt;
            cmerr_r <= cmerr_nxt;
            pos_r <= pos_nxt;
        end
    end

    // Motion, torque, home and clear interlocks
    logic busy_nxt, tl_nxt, clr_nxt, fix_nxt;
    always_comb begin
        busy_nxt = mode_nxt || state_nxt != ST_IDLE;
        tl_nxt = torque_limit_req_i && !busy_nxt;
        fix_nxt = home_mode_i && home_set_start_i && !home_d_r && rev_done_i
            && !busy_nxt;
        clr_nxt = clear_req_i && home_mode_i && !busy_nxt;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            start_d_r <= 1'b0;
            servo_d_r <= 1'b0;
            home_d_r <= 1'b0;
            busy_o <= 1'b0;
            hold_motion_o <= 1'b0;
            torque_limit_o <= 1'b0;
            home_fix_o <= 1'b0;
            position_clear_input_o <= 1'b0;
            servo_on_input_o <= 1'b0;
        end else begin
            start_d_r <= xfer_start_i;
            servo_d_r <= servo_on_req_i;
            home_d_r <= home_set_start_i;
            busy_o <= busy_nxt;
            hold_motion_o <= busy_nxt;
            torque_limit_o <= tl_nxt;
            home_fix_o <= fix_nxt;
            position_clear_input_o <= clr_nxt;
            servo_on_input_o <= servo_on_req_i;
        end
    end

    assign abs_mode_o = mode_r;
    assign abs_req_o = req_r;
    assign pos_valid_o = valid_r;
    assign csum_err_o = cserr_r;
    assign comm_err_o = cmerr_r;
    assign pos_lo_o = pos_r[HALF_W-1:0];
    assign pos_hi_o = pos_r[POS_W-1:HALF_W];
    assign brake_relay_o = pin_r[3];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_retry_cap;
        state_r == ST_RETRY_WAIT |-> retry_r != '0 && !csum_err_o;
    endproperty
    a_retry_cap: assert property (p_retry_cap) else $error("retry without count");
    property p_csum_err;
        $rose(csum_err_o) |-> retry_r == MAX_RETRIES && !pos_valid_o && !abs_mode_o;
    endproperty
    a_csum_err: assert property (p_csum_err) else $error("checksum error too early");
    property p_req_time;
        req_tmr_r <= TMR_W'(REQ_TO_CYC) + TMR_W'(1);
    endproperty
    a_req_time: assert property (p_req_time) else $error("request held past limit");
    property p_comm_err;
        $rose(comm_err_o) |-> !abs_mode_o && !abs_req_o ##1 state_r == ST_IDLE;
    endproperty
    a_comm_err: assert property (p_comm_err) else $error("handshake kept after error");
    property p_dwell;
        $fell(abs_req_o) && !comm_err_o |-> $past(tmr_r) == TMR_W'(SAMPLE_CYC - 1);
    endproperty
    a_dwell: assert property (p_dwell) else $error("sampled before delay");
    property p_hold;
        abs_mode_o |-> hold_motion_o && !torque_limit_o;
    endproperty
    a_hold: assert property (p_hold) else $error("motion allowed in transfer");
    property p_clear;
        position_clear_input_o |-> $past(home_mode_i) && !busy_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear outside home return");
    property p_home;
        home_fix_o |-> $past(rev_done_i) && $past(home_mode_i);
    endproperty
    a_home: assert property (p_home) else $error("home set without revolution");
    property p_steps;
        state_r == ST_CHECK |-> step_r == ALL_STEPS && $past(state_r) == ST_WAIT_REL;
    endproperty
    a_steps: assert property (p_steps) else $error("wrong step count");
    property p_req_rise;
        $rose(abs_req_o) |-> $past(!rts_f);
    endproperty
    a_req_rise: assert property (p_req_rise) else $error("request while strobe high");
    c_done: cover property ($rose(pos_valid_o));
    c_retry: cover property (state_r == ST_RETRY_WAIT);
    c_csum: cover property ($rose(csum_err_o));
    c_comm: cover property ($rose(comm_err_o));
endmodule : prh_position_report_host

// [bench/prh_amp_model.sv]
// Behavioural amplifier that answers the position report handshake
`timescale 1ns/100ps
module prh_amp_model (
    // Clock
    input wire logic ref_clk_i,
    // Controller pins
    input wire logic servo_on_i,
    input wire logic abs_mode_i,
    input wire logic abs_req_i,
    input wire logic torque_limit_i,
    // Test controls
    input wire logic [31:0] pos_i,
    input wire logic [2:0] bad_i,
    input wire logic rearm_i,
    input wire logic stall_i,
    input wire logic [3:0] function_select_param_i,
    // Amplifier pins
    output logic [1:0] amp_data_o,
    output logic amp_rts_o,
    output logic amp_brake_o
);
    logic rts_r = 1'b0;
    logic [1:0] dat_r = 2'h0;
    logic [4:0] idx_r = 5'h0;
    logic [2:0] att_r = 3'h0;

    function automatic logic [1:0] grp(input logic [4:0] i);
        logic [5:0] s;
        int j;
        s = 6'h0;
        j = int'(i);
        for (int k = 0; k < 16; k++) begin
            s = s + 6'(pos_i[2*k +: 2]);
        end
        // Broken sum on the first attempts so the controller must retry
        if (att_r < bad_i) begin
            s = s ^ 6'h01;
        end
        if (j < 16) begin
            return pos_i[2*j +: 2];
        end
        return s[2*(j-16) +: 2];
    endfunction : grp

    always @(posedge ref_clk_i) begin
        if (!abs_mode_i) begin
            if (idx_r != 5'h0) att_r <= att_r + 3'h1;
            idx_r <= 5'h0;
            rts_r <= 1'b0;
        end else if (abs_req_i && !rts_r && !stall_i) begin
            dat_r <= grp(idx_r);
            rts_r <= 1'b1;
        end else if (!abs_req_i && rts_r) begin
            // Released lines show the inverse so stale bits never match
            dat_r <= ~dat_r;
            rts_r <= 1'b0;
            idx_r <= idx_r + 5'h1;
        end
        if (rearm_i) att_r <= 3'h0;
    end

    assign amp_data_o = dat_r;
    assign amp_rts_o = abs_mode_i ? rts_r : torque_limit_i;
    assign amp_brake_o = (function_select_param_i == 4'h1) && servo_on_i;
endmodule : prh_amp_model

// [bench/test_position_report_handshake.sv]
// Self-checking bench for the position report handshake controller
`timescale 1ns/100ps
module test_position_report_handshake;
    import prh_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic servo_on_input = 1'b0, xst = 1'b0, tqr = 1'b0, hmode = 1'b0, hset = 1'b0;
    logic revd = 1'b0, clr = 1'b0, rearm = 1'b0, stall = 1'b0, req_d = 1'b0;
    logic [31:0] pos = 32'h0;
    logic [2:0] bad = 3'h0;
    logic [3:0] fsel = 4'h0;
    logic [15:0] plo, phi;
    logic pval, busy, cerr, merr, hold, hfix, brk;
    logic [1:0] adat;
    logic arts, abrk, son_p, mode, req, tq_p, clr_p;
    int num_errors = 0, checks_done = 0, reqs = 0, fixes = 0;

    prh_position_report_host #(.SAMPLE_CYC(4), .MODE_TO_CYC(20000), .REQ_TO_CYC(2000),
        .RTS_TO_CYC(500), .RETRY_CYC(10)) prh_position_report_host_inst (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .servo_on_req_i(servo_on_input),
        .xfer_start_i(xst), .torque_limit_req_i(tqr), .home_mode_i(hmode),
        .home_set_start_i(hset), .rev_done_i(revd), .clear_req_i(clr),
        .pos_lo_o(plo), .pos_hi_o(phi), .pos_valid_o(pval), .busy_o(busy),
        .csum_err_o(cerr), .comm_err_o(merr), .hold_motion_o(hold),
        .home_fix_o(hfix), .brake_relay_o(brk), .amp_data_i(adat),
        .amp_rts_i(arts), .amp_brake_i(abrk), .servo_on_input_o(son_p),
        .abs_mode_o(mode), .abs_req_o(req), .torque_limit_o(tq_p),
        .position_clear_input_o(clr_p));

    prh_amp_model prh_amp_model_inst (.ref_clk_i(ref_clk_i), .servo_on_i(son_p),
        .abs_mode_i(mode), .abs_req_i(req), .torque_limit_i(tq_p), .pos_i(pos),
        .bad_i(bad), .rearm_i(rearm), .stall_i(stall), .function_select_param_i(fsel),
        .amp_data_o(adat), .amp_rts_o(arts), .amp_brake_o(abrk));

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        req_d <= req;
        if (req && !req_d) reqs++;
        if (hfix) fixes++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // One full receive, started by a rise on the resend trigger
    task automatic xfer(input logic [31:0] p, input logic [2:0] b);
        int n;
        pos = p;
        bad = b;
        rearm = 1'b1;
        reqs = 0;
        servo_on_input = 1'b1;
        step(1);
        rearm = 1'b0;
        xst = 1'b1;
        step(3);
        chk("busy_on", busy, 1'b1);
        step(40);
        chk("torque_limit_gated", tq_p, 1'b0);
        chk("hold_motion", hold, 1'b1);
        xst = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 8000) begin
            step(1);
            n++;
        end
        chk("busy_off", busy, 1'b0);
    endtask : xfer

    task automatic good_xfer();
        xfer(32'hc3a5_1e69, 3'h0);
        chk("pos_lo", plo, 16'h1e69);
        chk("pos_hi", phi, 16'hc3a5);
        chk("pos_valid", pval, 1'b1);
        chk("csum_err", cerr, 1'b0);
        chk("steps", reqs, 19);
        chk("servo_on_pin", son_p, 1'b1);
        chk("torque_limit_idle", tq_p, 1'b1);
    endtask : good_xfer

    task automatic retry_xfers();
        xfer(32'hffff_ffff, 3'h3);
        chk("retry_valid", pval, 1'b1);
        chk("retry_csum_err", cerr, 1'b0);
        chk("retry_steps", reqs, 76);
        chk("retry_hi", phi, 16'hffff);
        xfer(32'h1234_5678, 3'h4);
        chk("exhaust_csum_err", cerr, 1'b1);
        chk("exhaust_valid", pval, 1'b0);
        chk("exhaust_steps", reqs, 76);
    endtask : retry_xfers

    task automatic stall_xfer();
        stall = 1'b1;
        xfer(32'h0000_0001, 3'h0);
        chk("comm_err", merr, 1'b1);
        chk("comm_valid", pval, 1'b0);
        chk("comm_mode_off", mode, 1'b0);
        stall = 1'b0;
        xfer(32'h0000_0001, 3'h0);
        chk("comm_err_cleared", merr, 1'b0);
        chk("recovered_lo", plo, 16'h0001);
    endtask : stall_xfer

    task automatic home_and_clear();
        clr = 1'b1;
        step(4);
        chk("clear_outside_home", clr_p, 1'b0);
        fixes = 0;
        revd = 1'b1;
        hset = 1'b1;
        step(4);
        chk("fix_outside_home", fixes, 0);
        hset = 1'b0;
        revd = 1'b0;
        hmode = 1'b1;
        step(4);
        chk("clear_in_home", clr_p, 1'b1);
        hset = 1'b1;
        step(4);
        chk("fix_before_rev", fixes, 0);
        hset = 1'b0;
        revd = 1'b1;
        step(4);
        hset = 1'b1;
        step(4);
        chk("fix_once", fixes, 1);
        {hset, hmode, clr} = 3'h0;
    endtask : home_and_clear

    task automatic brake_check();
        fsel = 4'h0;
        step(8);
        chk("brake_off", brk, 1'b0);
        fsel = 4'h1;
        step(8);
        chk("brake_on", brk, 1'b1);
    endtask : brake_check

    initial begin
        step(16);
        rst_n_i = 1'b1;
        tqr = 1'b1;
        step(4);
        good_xfer();
        retry_xfers();
        stall_xfer();
        home_and_clear();
        brake_check();
        tally_and_finish();
    end

    // Runs take a few thousand cycles; the limit leaves ample margin
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        num_errors++;
        tally_and_finish();
    end
endmodule : test_position_report_handshake
